// >>> verilog/fsef_pkg.sv
// constants, types and register map of the flash status flag bank
package fsef_pkg;

// Overview of operation
// - writing 1 to done bit 7 launches command
// - done stays low until finish or violation
// - sequence or illegal command sets access error
// - access error set blocks every launch
// - access error: write 1 clears, 0 keeps
// - protected program or erase sets violation bit
// - violation: write 1 clears, 0 keeps
// - violation set blocks launch and sequences
// - busy bit 3 reads one while running
// - bit 2 always reads zero
// - completion field flags execution or reset errors
// - writes change busy or completion field only by launching
// - reset sequence fault may alter status value
// - double fault or collision sets bit 1
// - unsuppressed single fault or collision sets bit 0
// - fault flags: write 1 clears, 0 keeps
// - ecc sets one flag, collision sets both
// - fault flags stored one cycle after read
// - done flag with enable requests interrupt
// - fault flags with enables request interrupts
// - suppression hides single faults and interrupt
// - forced double fault on every array read

// ****************************************************************
// widths and register offsets
// ****************************************************************
localparam int         FSEF_AW          = 4;
localparam int         FSEF_DW          = 8;
localparam logic [3:0] FSEF_OFF_CONFIG  = 4'h0;
localparam logic [3:0] FSEF_OFF_FCFG    = 4'h1;
localparam logic [3:0] FSEF_OFF_STATUS  = 4'h2;
localparam logic [3:0] FSEF_OFF_FAULT   = 4'h3;

// ****************************************************************
// field positions
// ****************************************************************
localparam int FSEF_CFG_CC_IE     = 7;
localparam int FSEF_CFG_SUPPRESS  = 4;
localparam int FSEF_CFG_FORCE_DBL = 1;
localparam int FSEF_CFG_FORCE_SGL = 0;
localparam int FSEF_FCFG_DBL_IE   = 1;
localparam int FSEF_FCFG_SGL_IE   = 0;
localparam int FSEF_ST_DONE       = 7;
localparam int FSEF_ST_ACCESS_ERROR_FLAG     = 5;
localparam int FSEF_ST_PVIOL      = 4;
localparam int FSEF_ST_BUSY       = 3;
localparam int FSEF_ST_CSTAT      = 0;
localparam int FSEF_FLT_DBL       = 1;
localparam int FSEF_FLT_SGL       = 0;

// ****************************************************************
// sticky flag slots and reset values
// ****************************************************************
localparam int         FSEF_NFLAG       = 4;
localparam int         FSEF_F_ACC       = 0;
localparam int         FSEF_F_PV        = 1;
localparam int         FSEF_F_DBL       = 2;
localparam int         FSEF_F_SGL       = 3;
localparam logic       FSEF_IE_RST      = 1'b0;
localparam logic [1:0] FSEF_CSTAT_RST   = 2'h0;
localparam logic [3:0] FSEF_FLAGS_RST   = 4'h0;

// ****************************************************************
// types
// ****************************************************************
typedef enum logic {FSEF_IDLE, FSEF_RUN} fsef_cmd_state_t;

typedef struct packed {
    logic       finish;
    logic [1:0] status;
    logic       seq_error;
    logic       prot_error;
} fsef_cmd_evt_t;

typedef struct packed {
    logic       done;
    logic       ecc_corr;
    logic       ecc_uncorr;
    logic       collide;
} fsef_rd_evt_t;

typedef struct packed {
    logic       valid;
    logic [1:0] status;
} fsef_init_t;

typedef struct packed {
    logic       set_dbl;
    logic       set_sgl;
} fsef_fault_set_t;

typedef struct packed {
    logic [FSEF_NFLAG-1:0] flags;
} fsef_flag_st_t;

typedef struct packed {
    fsef_cmd_state_t state;
    logic            cc_ie;
    logic            suppress;
    logic            force_dbl;
    logic            force_sgl;
    logic            dbl_ie;
    logic            sgl_ie;
    logic [1:0]      cstat;
    logic            launch;
    logic            seq_allow;
    logic            irq_cmd;
    logic            irq_dbl;
    logic            irq_sgl;
    logic [7:0]      rdata;
} fsef_top_st_t;

endpackage

// >>> verilog/fsef_flag_bank.sv
// sticky write-one-to-clear flags of the status bank
`timescale 1ns/1ps
module fsef_flag_bank (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            resetn,
    // set and clear requests
    input  wire logic [fsef_pkg::FSEF_NFLAG-1:0] set,
    input  wire logic [fsef_pkg::FSEF_NFLAG-1:0] clr,
    // flag values
    output logic      [fsef_pkg::FSEF_NFLAG-1:0] flags,
    output logic      [fsef_pkg::FSEF_NFLAG-1:0] flags_nxt
);

    fsef_pkg::fsef_flag_st_t st_q;
    fsef_pkg::fsef_flag_st_t st_d;

    for (genvar i = 0; i < fsef_pkg::FSEF_NFLAG; i++) begin : g_flag
        // set wins so an event during a clear is not lost
        assign flags_nxt[i] = set[i] | (st_q.flags[i] & ~clr[i]);

        property p_set_wins;
            @(posedge clk) disable iff (!resetn)
            (set[i] && clr[i]) |=> st_q.flags[i];
        endproperty
        a_set_wins: assert property (p_set_wins)
            else $error("flag lost a set during clear");
    end

    always_comb begin
        st_d       = st_q;
        st_d.flags = flags_nxt;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q.flags <= fsef_pkg::FSEF_FLAGS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;

endmodule

// >>> verilog/fsef_fault_capture.sv
// classifies flash array read faults, one cycle late
`timescale 1ns/1ps
module fsef_fault_capture (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // read result and controls
    input  wire fsef_pkg::fsef_rd_evt_t    rd_evt,
    input  wire logic                      suppress,
    input  wire logic                      force_dbl,
    input  wire logic                      force_sgl,
    // flag set requests
    output fsef_pkg::fsef_fault_set_t      fault_set
);

    fsef_pkg::fsef_fault_set_t st_q;
    fsef_pkg::fsef_fault_set_t st_d;

    // the staging flop is the one-cycle store delay
    always_comb begin
        st_d = '0;
        if (rd_evt.done) begin
            st_d.set_dbl = rd_evt.ecc_uncorr | rd_evt.collide
                         | force_dbl;
            // an uncorrectable fault masks the single one
            st_d.set_sgl = rd_evt.collide
                         | (~suppress & ~rd_evt.ecc_uncorr & ~force_dbl
                            & (rd_evt.ecc_corr | force_sgl));
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fault_set = st_q;

    property p_ecc_exclusive;
        @(posedge clk) disable iff (!resetn)
        (rd_evt.done && !rd_evt.collide) |=> !(st_q.set_dbl && st_q.set_sgl);
    endproperty
    a_ecc_exclusive: assert property (p_ecc_exclusive)
        else $error("ecc fault set both flags");

    property p_suppress;
        @(posedge clk) disable iff (!resetn)
        (rd_evt.done && suppress && !rd_evt.collide) |=> !st_q.set_sgl;
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("suppressed single fault reported");

endmodule

// >>> verilog/fsef_top.sv
// top of the flash status and fault flag register bank
`timescale 1ns/1ps
module fsef_top (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // register port
    input  wire logic [fsef_pkg::FSEF_AW-1:0] reg_addr,
    input  wire logic [fsef_pkg::FSEF_DW-1:0] reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [fsef_pkg::FSEF_DW-1:0] reg_rdata,
    // command engine and reset sequence
    input  wire fsef_pkg::fsef_cmd_evt_t      cmd_evt,
    input  wire fsef_pkg::fsef_init_t         init_evt,
    output logic                              cmd_launch,
    output logic                              seq_allow,
    // array reads
    input  wire fsef_pkg::fsef_rd_evt_t       rd_evt,
    // interrupt requests
    output logic                              irq_cmd_done,
    output logic                              irq_dbl_fault,
    output logic                              irq_sgl_fault
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    fsef_pkg::fsef_top_st_t          st_q;
    fsef_pkg::fsef_top_st_t          st_d;
    fsef_pkg::fsef_fault_set_t       fault_set;
    logic [fsef_pkg::FSEF_NFLAG-1:0] flag_set;
    logic [fsef_pkg::FSEF_NFLAG-1:0] flag_clr;
    logic [fsef_pkg::FSEF_NFLAG-1:0] flags;
    logic [fsef_pkg::FSEF_NFLAG-1:0] flags_nxt;
    logic                            wr_cfg;
    logic                            wr_fcfg;
    logic                            wr_stat;
    logic                            wr_flt;
    logic                            violation;
    logic                            launch_ok;
    logic                            running;

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign wr_cfg  = reg_wr && (reg_addr == fsef_pkg::FSEF_OFF_CONFIG);
    assign wr_fcfg = reg_wr && (reg_addr == fsef_pkg::FSEF_OFF_FCFG);
    assign wr_stat = reg_wr && (reg_addr == fsef_pkg::FSEF_OFF_STATUS);
    assign wr_flt  = reg_wr && (reg_addr == fsef_pkg::FSEF_OFF_FAULT);
    assign running = (st_q.state == fsef_pkg::FSEF_RUN);

    // ****************************************************************
    // sticky flags
    // ****************************************************************
    assign violation = cmd_evt.seq_error | cmd_evt.prot_error;

    assign flag_set[fsef_pkg::FSEF_F_ACC] = cmd_evt.seq_error;
    assign flag_set[fsef_pkg::FSEF_F_PV]  = cmd_evt.prot_error;
    assign flag_set[fsef_pkg::FSEF_F_DBL] = fault_set.set_dbl;
    assign flag_set[fsef_pkg::FSEF_F_SGL] = fault_set.set_sgl;

    // a zero in the write data leaves the flag alone
    assign flag_clr[fsef_pkg::FSEF_F_ACC] =
        wr_stat && reg_wdata[fsef_pkg::FSEF_ST_ACCESS_ERROR_FLAG];
    assign flag_clr[fsef_pkg::FSEF_F_PV]  =
        wr_stat && reg_wdata[fsef_pkg::FSEF_ST_PVIOL];
    assign flag_clr[fsef_pkg::FSEF_F_DBL] =
        wr_flt && reg_wdata[fsef_pkg::FSEF_FLT_DBL];
    assign flag_clr[fsef_pkg::FSEF_F_SGL] =
        wr_flt && reg_wdata[fsef_pkg::FSEF_FLT_SGL];

    // flags seen before this write count, so one write cannot
    // clear an error and launch at once
    assign launch_ok = wr_stat && reg_wdata[fsef_pkg::FSEF_ST_DONE]
                    && !flags[fsef_pkg::FSEF_F_ACC]
                    && !flags[fsef_pkg::FSEF_F_PV]
                    && !violation;

    fsef_flag_bank u_flags (
        .clk       (clk),
        .resetn    (resetn),
        .set       (flag_set),
        .clr       (flag_clr),
        .flags     (flags),
        .flags_nxt (flags_nxt)
    );

    fsef_fault_capture u_capture (
        .clk       (clk),
        .resetn    (resetn),
        .rd_evt    (rd_evt),
        .suppress  (st_q.suppress),
        .force_dbl (st_q.force_dbl),
        .force_sgl (st_q.force_sgl),
        .fault_set (fault_set)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [7:0] cfg_view;
        logic [7:0] fcfg_view;
        logic [7:0] stat_view;
        logic [7:0] flt_view;
        cfg_view  = 8'h00;
        fcfg_view = 8'h00;
        stat_view = 8'h00;
        flt_view  = 8'h00;
        st_d        = st_q;
        st_d.launch = 1'b0;

        if (wr_cfg) begin
            st_d.cc_ie     = reg_wdata[fsef_pkg::FSEF_CFG_CC_IE];
            st_d.suppress  = reg_wdata[fsef_pkg::FSEF_CFG_SUPPRESS];
            st_d.force_dbl = reg_wdata[fsef_pkg::FSEF_CFG_FORCE_DBL];
            st_d.force_sgl = reg_wdata[fsef_pkg::FSEF_CFG_FORCE_SGL];
        end
        if (wr_fcfg) begin
            st_d.dbl_ie = reg_wdata[fsef_pkg::FSEF_FCFG_DBL_IE];
            st_d.sgl_ie = reg_wdata[fsef_pkg::FSEF_FCFG_SGL_IE];
        end

        // busy and completion field have no write path
        case (st_q.state)
            fsef_pkg::FSEF_IDLE: begin
                if (launch_ok) begin
                    st_d.state  = fsef_pkg::FSEF_RUN;
                    st_d.launch = 1'b1;
                    st_d.cstat  = fsef_pkg::FSEF_CSTAT_RST;
                end
            end
            fsef_pkg::FSEF_RUN: begin
                if (cmd_evt.finish) begin
                    st_d.state = fsef_pkg::FSEF_IDLE;
                    st_d.cstat = cmd_evt.status;
                end else if (violation) begin
                    st_d.state = fsef_pkg::FSEF_IDLE;
                end
            end
            default: begin
                st_d.state = fsef_pkg::FSEF_IDLE;
            end
        endcase

        // reset sequence result overrides the nominal reset value
        if (init_evt.valid) begin
            st_d.cstat = init_evt.status;
        end

        st_d.seq_allow = !flags_nxt[fsef_pkg::FSEF_F_PV];
        st_d.irq_cmd   = st_d.cc_ie
                      && (st_d.state == fsef_pkg::FSEF_IDLE);
        st_d.irq_dbl   = st_d.dbl_ie
                      && flags_nxt[fsef_pkg::FSEF_F_DBL];
        st_d.irq_sgl   = st_d.sgl_ie
                      && flags_nxt[fsef_pkg::FSEF_F_SGL];

        cfg_view[fsef_pkg::FSEF_CFG_CC_IE]     = st_q.cc_ie;
        cfg_view[fsef_pkg::FSEF_CFG_SUPPRESS]  = st_q.suppress;
        cfg_view[fsef_pkg::FSEF_CFG_FORCE_DBL] = st_q.force_dbl;
        cfg_view[fsef_pkg::FSEF_CFG_FORCE_SGL] = st_q.force_sgl;
        fcfg_view[fsef_pkg::FSEF_FCFG_DBL_IE]  = st_q.dbl_ie;
        fcfg_view[fsef_pkg::FSEF_FCFG_SGL_IE]  = st_q.sgl_ie;
        // bit 2 and unassigned bits stay at zero
        stat_view[fsef_pkg::FSEF_ST_DONE]   = !running;
        stat_view[fsef_pkg::FSEF_ST_ACCESS_ERROR_FLAG] = flags[fsef_pkg::FSEF_F_ACC];
        stat_view[fsef_pkg::FSEF_ST_PVIOL]  = flags[fsef_pkg::FSEF_F_PV];
        stat_view[fsef_pkg::FSEF_ST_BUSY]   = running;
        stat_view[fsef_pkg::FSEF_ST_CSTAT+:2] = st_q.cstat;
        flt_view[fsef_pkg::FSEF_FLT_DBL]    = flags[fsef_pkg::FSEF_F_DBL];
        flt_view[fsef_pkg::FSEF_FLT_SGL]    = flags[fsef_pkg::FSEF_F_SGL];

        // unmapped offsets read zero; data stand one cycle only
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                fsef_pkg::FSEF_OFF_CONFIG: st_d.rdata = cfg_view;
                fsef_pkg::FSEF_OFF_FCFG:   st_d.rdata = fcfg_view;
                fsef_pkg::FSEF_OFF_STATUS: st_d.rdata = stat_view;
                fsef_pkg::FSEF_OFF_FAULT:  st_d.rdata = flt_view;
                default:                   st_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q.state     <= fsef_pkg::FSEF_IDLE;
            st_q.cc_ie     <= fsef_pkg::FSEF_IE_RST;
            st_q.suppress  <= fsef_pkg::FSEF_IE_RST;
            st_q.force_dbl <= fsef_pkg::FSEF_IE_RST;
            st_q.force_sgl <= fsef_pkg::FSEF_IE_RST;
            st_q.dbl_ie    <= fsef_pkg::FSEF_IE_RST;
            st_q.sgl_ie    <= fsef_pkg::FSEF_IE_RST;
            st_q.cstat     <= fsef_pkg::FSEF_CSTAT_RST;
            st_q.launch    <= 1'b0;
            st_q.seq_allow <= 1'b1;
            st_q.irq_cmd   <= 1'b0;
            st_q.irq_dbl   <= 1'b0;
            st_q.irq_sgl   <= 1'b0;
            st_q.rdata     <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata     = st_q.rdata;
    assign cmd_launch    = st_q.launch;
    assign seq_allow     = st_q.seq_allow;
    assign irq_cmd_done  = st_q.irq_cmd;
    assign irq_dbl_fault = st_q.irq_dbl;
    assign irq_sgl_fault = st_q.irq_sgl;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_launch;
        @(posedge clk) disable iff (!resetn)
        (!running && launch_ok) |=> (cmd_launch && running);
    endproperty
    a_launch: assert property (p_launch)
        else $error("clean launch write did not start a command");

    property p_hold_low;
        @(posedge clk) disable iff (!resetn)
        (running && !cmd_evt.finish && !violation) |=> running;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("done flag rose without finish or violation");

    property p_finish;
        @(posedge clk) disable iff (!resetn)
        (running && cmd_evt.finish) |=> (!running && st_q.cstat
            == $past(cmd_evt.status));
    endproperty
    a_finish: assert property (p_finish)
        else $error("finish did not set done and completion field");

    property p_acc_blocks;
        @(posedge clk) disable iff (!resetn)
        (wr_stat && flags[fsef_pkg::FSEF_F_ACC]) |=> !cmd_launch;
    endproperty
    a_acc_blocks: assert property (p_acc_blocks)
        else $error("launch while access error set");

    property p_pv_blocks;
        @(posedge clk) disable iff (!resetn)
        flags[fsef_pkg::FSEF_F_PV] |-> (!seq_allow ##1 !cmd_launch);
    endproperty
    a_pv_blocks: assert property (p_pv_blocks)
        else $error("launch or sequence allowed during violation");

    property p_acc_set;
        @(posedge clk) disable iff (!resetn)
        cmd_evt.seq_error |=> flags[fsef_pkg::FSEF_F_ACC];
    endproperty
    a_acc_set: assert property (p_acc_set)
        else $error("access error not flagged");

    property p_acc_w0;
        @(posedge clk) disable iff (!resetn)
        (wr_stat && !reg_wdata[fsef_pkg::FSEF_ST_ACCESS_ERROR_FLAG]
            && flags[fsef_pkg::FSEF_F_ACC]) |=> flags[fsef_pkg::FSEF_F_ACC];
    endproperty
    a_acc_w0: assert property (p_acc_w0)
        else $error("writing zero cleared access error");

    property p_stat_read;
        @(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == fsef_pkg::FSEF_OFF_STATUS) |=>
            (reg_rdata[fsef_pkg::FSEF_ST_BUSY] == $past(running)
             && reg_rdata[fsef_pkg::FSEF_ST_DONE] == !$past(running)
             && reg_rdata[2] == 1'b0 && reg_rdata[6] == 1'b0);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status readback wrong");

    property p_dbl_delay;
        @(posedge clk) disable iff (!resetn)
        (rd_evt.done && rd_evt.ecc_uncorr) |=> ##1
            flags[fsef_pkg::FSEF_F_DBL];
    endproperty
    a_dbl_delay: assert property (p_dbl_delay)
        else $error("double fault not stored one cycle late");

    property p_collide;
        @(posedge clk) disable iff (!resetn)
        (rd_evt.done && rd_evt.collide) |-> ##2
            (flags[fsef_pkg::FSEF_F_DBL] && flags[fsef_pkg::FSEF_F_SGL]);
    endproperty
    a_collide: assert property (p_collide)
        else $error("collision did not set both fault flags");

    property p_force_dbl;
        @(posedge clk) disable iff (!resetn)
        (rd_evt.done && st_q.force_dbl) |-> ##2 flags[fsef_pkg::FSEF_F_DBL];
    endproperty
    a_force_dbl: assert property (p_force_dbl)
        else $error("forced double fault not flagged");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
        (st_q.dbl_ie && flags[fsef_pkg::FSEF_F_DBL] && !$past(wr_fcfg))
            |-> irq_dbl_fault;
    endproperty
    a_irq: assert property (p_irq)
        else $error("double fault interrupt missing");

endmodule

// >>> verif/tb_top.sv
// self-checking bench for the flash status and fault flag bank
`timescale 1ns/1ps
module tb_top;
// ****************************************************************
// signals and design
// ****************************************************************
localparam logic [3:0] A_CF = fsef_pkg::FSEF_OFF_CONFIG;
localparam logic [3:0] A_FC = fsef_pkg::FSEF_OFF_FCFG;
localparam logic [3:0] A_ST = fsef_pkg::FSEF_OFF_STATUS;
localparam logic [3:0] A_FL = fsef_pkg::FSEF_OFF_FAULT;
logic                    clk;
logic                    resetn;
logic [3:0]              reg_addr;
logic [7:0]              reg_wdata;
logic                    reg_wr;
logic                    reg_rd;
logic [7:0]              reg_rdata;
fsef_pkg::fsef_cmd_evt_t cmd_evt;
fsef_pkg::fsef_init_t    init_evt;
fsef_pkg::fsef_rd_evt_t  rd_evt;
logic                    cmd_launch;
logic                    seq_allow;
logic                    irq_cmd_done;
logic                    irq_dbl_fault;
logic                    irq_sgl_fault;
logic                    rd_seen;
logic [7:0]              exp_q[$];
logic [7:0]              cfg;
logic [3:0]              r;
logic [1:0]              ie;
logic [1:0]              s;
logic [1:0]              e;
int                      num_errors;
int                      checks;
int                      cycles;
fsef_top u_fsef_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_evt(cmd_evt), .init_evt(init_evt),
    .cmd_launch(cmd_launch), .seq_allow(seq_allow), .rd_evt(rd_evt),
    .irq_cmd_done(irq_cmd_done), .irq_dbl_fault(irq_dbl_fault),
    .irq_sgl_fault(irq_sgl_fault));
// ****************************************************************
// bus tasks and comparison
// ****************************************************************
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        num_errors++;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic tally_and_finish;
    if (num_errors == 0 && checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(x);
    @(posedge clk);
    reg_rd   <= 1'b0;
endtask
task automatic cmd(input logic [4:0] v);
    @(posedge clk);
    cmd_evt <= v;
    @(posedge clk);
    cmd_evt <= '0;
endtask
// read event, then a fault register read one cycle late that must miss it
task automatic flt;
    @(posedge clk);
    rd_evt   <= r;
    @(posedge clk);
    rd_evt   <= '0;
    reg_rd   <= 1'b1;
    reg_addr <= A_FL;
    exp_q.push_back(8'h00);
    @(posedge clk);
    reg_rd   <= 1'b0;
    wr(A_FL, 8'h00);
    rd(A_FL, {6'h0, e});
    #1 chk({6'h0, irq_dbl_fault, irq_sgl_fault}, {6'h0, e & ie});
    wr(A_FL, 8'h03);
    rd(A_FL, 8'h00);
endtask
// ****************************************************************
// clock, watcher and timeout
// ****************************************************************
initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
always @(posedge clk) begin
    if (rd_seen)
        chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
end
// ceiling well above the roughly 680 cycles the sequence needs
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
        num_errors++;
        tally_and_finish();
    end
end
// ****************************************************************
// main sequence
// ****************************************************************
initial begin
    resetn = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
    reg_rd = 1'b0; cmd_evt = '0; init_evt = '0; rd_evt = '0;
    rd_seen = 1'b0; num_errors = 0; checks = 0; cycles = 0;
    void'($urandom(89));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(A_CF, 8'h00);
    rd(A_FC, 8'h00);
    rd(A_ST, 8'h80);
    rd(A_FL, 8'h00);
    wr(A_CF, 8'hff);
    wr(A_FC, 8'hff);
    wr(4'h5, 8'hff);
    wr(A_ST, 8'h4f);
    rd(A_CF, 8'h93);
    rd(A_FC, 8'h03);
    rd(4'h5, 8'h00);
    rd(A_ST, 8'h80);
    wr(A_CF, 8'h00);
    wr(A_ST, 8'h80);
    #1 chk({7'h0, cmd_launch}, 8'h01);
    rd(A_ST, 8'h08);
    s = 2'($urandom);
    cmd({1'b1, s, 2'b00});
    rd(A_ST, 8'h80 | s);
    s = 2'($urandom);
    @(posedge clk);
    init_evt <= {1'b1, s};
    @(posedge clk);
    init_evt <= '0;
    rd(A_ST, 8'h80 | s);
    cmd(5'h02);
    rd(A_ST, 8'ha0 | s);
    wr(A_ST, 8'h80);
    #1 chk({7'h0, cmd_launch}, 8'h00);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'ha0 | s);
    wr(A_ST, 8'h20);
    rd(A_ST, 8'h80 | s);
    cmd(5'h01);
    #1 chk({7'h0, seq_allow}, 8'h00);
    wr(A_ST, 8'h80);
    rd(A_ST, 8'h90 | s);
    wr(A_ST, 8'h10);
    #1 chk({7'h0, seq_allow}, 8'h01);
    // a launch clears the completion field; a violation leaves it at 0
    wr(A_ST, 8'h80);
    cmd(5'h02);
    rd(A_ST, 8'ha0);
    @(posedge clk);
    cmd_evt   <= 5'h02;
    reg_wr    <= 1'b1;
    reg_addr  <= A_ST;
    reg_wdata <= 8'h20;
    @(posedge clk);
    cmd_evt   <= '0;
    reg_wr    <= 1'b0;
    rd(A_ST, 8'ha0);
    wr(A_ST, 8'h20);
    for (int i = 0; i < 40; i++) begin
        cfg = 8'($urandom) & 8'h93;
        ie  = 2'($urandom);
        r   = {1'b1, 3'($urandom)};
        e[1] = r[1] | r[0] | cfg[1];
        e[0] = r[0] | ((r[2] | cfg[0]) & !r[1] & !cfg[1] & !cfg[4]);
        wr(A_CF, cfg);
        wr(A_FC, {6'h0, ie});
        #1 chk({7'h0, irq_cmd_done}, {7'h0, cfg[7]});
        flt();
    end
    // let the watcher compare the last read before closing
    repeat (2) @(posedge clk);
    tally_and_finish();
end
endmodule
